// [pmli_lane_ctrl.sv]
// pmli_lane_ctrl: controller end of the per-lane parallel PHY interface
// assumes: PHY inputs are synchronous to pclk; user commands on clk;
// the receive stream is handed to the user on pclk
`timescale 1ns/1ps
`default_nettype none
`include "pmli_map.svh"

////////////////////////////////////////////////////////////////////////////
// Function
// - receive path is 8 bits at rates one and two, 32 at rate three.
// - every lane signal exists for each of eight lanes.
// - rate three coefficient word: pre 5:0, main 11:6, post 17:12.
// - rate three drives the 3-bit current receiver preset.
// - selector top bit zero when no idle inference is needed.
// - code 100: no comma/skip set in 128 us, rates one or two.
// - code 101: no training set in 1280 UI, rates one or two.
// - code 110: no idle exit in 2000 UI or 16000 UI.
// - code 111: no idle exit in 128 us, rate one only.
// - 2-bit power request: on, standby, low power, lowest power.
// - rate codes 00, 01, 10; code 11 never driven.
// - kind bit zero is data, one is control; rates one, two only.
// - invert request makes the PHY invert that lane's decoding.
module pmli_lane_ctrl
	import pmli_pkg::*;
#(
	parameter int LANES = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_rate,
	input wire logic [1:0] cmd_power,
	input wire logic [LANES-1:0] cmd_invert,
	input wire logic cmd_infer_needed,
	input wire logic [1:0] cmd_infer_code,
	input wire logic [5:0] cmd_pre,
	input wire logic [5:0] cmd_main,
	input wire logic [5:0] cmd_post,
	input wire logic [2:0] cmd_preset,
	output logic cmd_error,
	output logic [LANES-1:0] stat_idle,
	input wire logic pclk,
	output logic [LANES-1:0][17:0] tx_equaliser_coefficients,
	output logic [LANES-1:0][2:0] rx_preset_current,
	output logic [LANES-1:0][2:0] idle_inference_select,
	output logic [LANES-1:0][1:0] power_state_request,
	output logic [1:0] link_rate,
	output logic [LANES-1:0] rx_invert_request,
	input wire logic [LANES-1:0] phy_request_done,
	input wire logic [LANES-1:0] rx_block_begin,
	input wire logic [LANES-1:0][31:0] rx_lane_word,
	input wire logic [LANES-1:0][3:0] rx_symbol_kind,
	input wire logic [LANES-1:0] rx_idle_detected,
	input wire logic [LANES-1:0] rx_symbol_locked,
	input wire logic [LANES-1:0][2:0] rx_status_code,
	output logic [LANES-1:0][31:0] usr_rx_word,
	output logic [LANES-1:0][3:0] usr_rx_kind,
	output logic [LANES-1:0] usr_rx_valid,
	output logic [LANES-1:0] usr_rx_block,
	output logic [LANES-1:0][2:0] usr_rx_status
);

	////////////////////////////////////////////////////////////////////////
	// user side: command capture on clk

	logic req_tgl_reg;
	logic ack_tgl_reg;
	logic ack_s1_reg;
	logic ack_s2_reg;
	logic err_reg;
	pmli_rate_t h_rate_reg;
	logic [1:0] h_power_reg;
	logic [LANES-1:0] h_invert_reg;
	logic [2:0] h_infer_reg;
	pmli_coef_t h_coef_reg;
	logic [2:0] h_preset_reg;
	logic [LANES-1:0] idle_s1_reg;
	logic [LANES-1:0] idle_s2_reg;
	wire cmd_take;
	wire [2:0] cmd_infer_req;
	wire [17:0] cmd_coef;

	// one command in flight: ready only after the far side acknowledged
	assign cmd_ready = (req_tgl_reg == ack_s2_reg);
	assign cmd_take = cmd_valid & cmd_ready;
	// top bit carries whether inference is needed at all
	assign cmd_infer_req = cmd_infer_needed ? {1'b1, cmd_infer_code}
		: `PMLI_INFER_NONE;
	// pack the three cursors at their field positions
	assign cmd_coef = ({12'h000, cmd_pre} << `PMLI_COEF_PRE_LSB)
		| ({12'h000, cmd_main} << `PMLI_COEF_MAIN_LSB)
		| ({12'h000, cmd_post} << `PMLI_COEF_POST_LSB);
	assign cmd_error = err_reg;
	assign stat_idle = idle_s2_reg;

	// hold registers stay stable while the request crosses
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			req_tgl_reg <= 1'b0;
			err_reg <= 1'b0;
			h_rate_reg <= `PMLI_RST_RATE;
			h_power_reg <= `PMLI_RST_PWR;
			h_invert_reg <= '0;
			h_infer_reg <= `PMLI_INFER_NONE;
			h_coef_reg <= 18'h0_0000;
			h_preset_reg <= 3'h0;
		end else if (cmd_take) begin
			req_tgl_reg <= ~req_tgl_reg;
			err_reg <= (cmd_rate == `PMLI_RATE_RSVD);
			h_rate_reg <= cmd_rate;
			h_power_reg <= cmd_power;
			h_invert_reg <= cmd_invert;
			h_infer_reg <= cmd_infer_req;
			h_coef_reg <= cmd_coef;
			h_preset_reg <= cmd_preset;
		end
	end

	// acknowledge toggle and idle levels come in through two flops
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
			idle_s1_reg <= '0;
			idle_s2_reg <= '0;
		end else begin
			ack_s1_reg <= ack_tgl_reg;
			ack_s2_reg <= ack_s1_reg;
			idle_s1_reg <= rx_idle_detected;
			idle_s2_reg <= idle_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link side: reset release and request crossing on pclk

	logic prst_s1_reg;
	logic prst_reg;
	logic req_s1_reg;
	logic req_s2_reg;
	logic req_s3_reg;
	pmli_state_t state_reg;
	pmli_state_t state_next;
	pmli_rate_t rate_reg;
	logic [1:0] power_reg;
	logic [LANES-1:0] invert_reg;
	logic [2:0] infer_reg;
	pmli_coef_t coef_reg;
	logic [2:0] preset_reg;
	logic [LANES-1:0] seen_reg;
	wire req_new;
	wire rate_ok;
	wire [1:0] rate_next;
	wire need_done;
	wire all_done;
	wire infer_legal;
	wire [2:0] infer_next;
	wire is_gen3;

	// reset asserts at once, releases on pclk
	always_ff @(posedge pclk or posedge sys_rst) begin
		if (sys_rst) begin
			prst_s1_reg <= 1'b1;
			prst_reg <= 1'b1;
		end else begin
			prst_s1_reg <= 1'b0;
			prst_reg <= prst_s1_reg;
		end
	end

	// reserved rate keeps the rate in use rather than drive it
	assign rate_ok = (h_rate_reg != `PMLI_RATE_RSVD);
	assign rate_next = rate_ok ? h_rate_reg : rate_reg;
	// only a power or rate change makes the PHY answer
	assign need_done = (rate_next != rate_reg) | (h_power_reg != power_reg);
	assign all_done = &(seen_reg | phy_request_done);
	assign req_new = req_s2_reg ^ req_s3_reg;
	assign is_gen3 = (rate_reg == `PMLI_RATE_GEN3);

	// each mechanism only where it is defined for the rate applied
	assign infer_legal =
		((h_infer_reg == `PMLI_INFER_COMSKP)
			& (rate_next != `PMLI_RATE_GEN3))
		| ((h_infer_reg == `PMLI_INFER_TS)
			& (rate_next != `PMLI_RATE_GEN3))
		| ((h_infer_reg == `PMLI_INFER_EXIT_UI)
			& (rate_next != `PMLI_RATE_GEN3))
		| ((h_infer_reg == `PMLI_INFER_EXIT_WIN)
			& (rate_next == `PMLI_RATE_GEN1));
	assign infer_next = infer_legal ? h_infer_reg
		: `PMLI_INFER_NONE;

	// apply in idle, then on a rate or power change wait for every lane to complete
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			st_idle: begin
				if (req_new && need_done) begin
					state_next = st_wait;
				end
			end
			st_wait: begin
				if (all_done) begin
					state_next = st_idle;
				end
			end
		endcase
	end

	// the third flop is only an edge reference for the second
	always_ff @(posedge pclk or posedge prst_reg) begin
		if (prst_reg) begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			req_s3_reg <= 1'b0;
		end else begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
			req_s3_reg <= req_s2_reg;
		end
	end

	// request fields change only from idle, so they hold while waiting
	always_ff @(posedge pclk or posedge prst_reg) begin
		if (prst_reg) begin
			state_reg <= st_idle;
			ack_tgl_reg <= 1'b0;
			rate_reg <= `PMLI_RST_RATE;
			power_reg <= `PMLI_RST_PWR;
			invert_reg <= '0;
			infer_reg <= `PMLI_INFER_NONE;
			coef_reg <= 18'h0_0000;
			preset_reg <= 3'h0;
			seen_reg <= '0;
		end else begin
			state_reg <= state_next;
			if (state_reg == st_idle && req_new) begin
				rate_reg <= rate_next;
				power_reg <= h_power_reg;
				invert_reg <= h_invert_reg;
				infer_reg <= infer_next;
				coef_reg <= h_coef_reg;
				preset_reg <= h_preset_reg;
				seen_reg <= '0;
				if (!need_done) begin
					ack_tgl_reg <= ~ack_tgl_reg;
				end
			end else if (state_reg == st_wait) begin
				seen_reg <= seen_reg | phy_request_done;
				if (all_done) begin
					ack_tgl_reg <= ~ack_tgl_reg;
				end
			end
		end
	end

	assign link_rate = rate_reg;

	////////////////////////////////////////////////////////////////////////
	// per-lane outputs and receive path

	genvar ln;
	generate
		for (ln = 0; ln < LANES; ln++) begin : g_lane
			wire [31:0] word_next;
			wire [3:0] kind_next;
			logic [31:0] word_reg;
			logic [3:0] kind_reg;
			logic valid_reg;
			logic block_reg;
			logic [2:0] status_reg;

			// same request on every lane except invert, taken per lane; equaliser only at rate three
			assign tx_equaliser_coefficients[ln] = is_gen3 ? coef_reg
				: 18'h0_0000;
			assign rx_preset_current[ln] = is_gen3 ? preset_reg
				: 3'h0;
			assign idle_inference_select[ln] = infer_reg;
			assign power_state_request[ln] = power_reg;
			assign rx_invert_request[ln] = invert_reg[ln];

			// narrow lanes use the low byte and one kind bit only
			assign word_next = is_gen3 ? rx_lane_word[ln]
				: rx_lane_word[ln] & `PMLI_NARROW_MASK;
			assign kind_next = is_gen3 ? 4'h0
				: rx_symbol_kind[ln] & `PMLI_NARROW_KIND;

			// one register stage; words still pass when unlocked, with valid low
			always_ff @(posedge pclk or posedge prst_reg) begin
				if (prst_reg) begin
					word_reg <= 32'h0000_0000;
					kind_reg <= 4'h0;
					valid_reg <= 1'b0;
					block_reg <= 1'b0;
					status_reg <= 3'h0;
				end else begin
					word_reg <= word_next;
					kind_reg <= kind_next;
					valid_reg <= rx_symbol_locked[ln];
					block_reg <= is_gen3 & rx_block_begin[ln];
					status_reg <= rx_status_code[ln];
				end
			end

			assign usr_rx_word[ln] = word_reg;
			assign usr_rx_kind[ln] = kind_reg;
			assign usr_rx_valid[ln] = valid_reg;
			assign usr_rx_block[ln] = block_reg;
			assign usr_rx_status[ln] = status_reg;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// checks on the link side

	a_rate_legal: assert property (@(posedge pclk) disable iff (prst_reg)
		link_rate != `PMLI_RATE_RSVD)
		else $error("reserved rate driven");
	a_lanes_copy: assert property (@(posedge pclk) disable iff (prst_reg)
		power_state_request[LANES-1] == power_state_request[0])
		else $error("lanes disagree on power request");
	a_coef_gen3: assert property (@(posedge pclk) disable iff (prst_reg)
		is_gen3 |-> tx_equaliser_coefficients[0][17:12] == coef_reg[17:12])
		else $error("post cursor misplaced");
	a_preset_gen3: assert property (@(posedge pclk) disable iff (prst_reg)
		!is_gen3 |-> rx_preset_current[0] == 3'h0)
		else $error("preset driven outside rate three");
	a_infer_comskp: assert property (@(posedge pclk) disable iff (prst_reg)
		idle_inference_select[0] == `PMLI_INFER_COMSKP |-> !is_gen3)
		else $error("comma skip inference at rate three");
	a_infer_ts: assert property (@(posedge pclk) disable iff (prst_reg)
		idle_inference_select[0] == `PMLI_INFER_TS |-> !is_gen3)
		else $error("training set inference at rate three");
	a_infer_exit: assert property (@(posedge pclk) disable iff (prst_reg)
		idle_inference_select[0] == `PMLI_INFER_EXIT_UI |-> !is_gen3)
		else $error("exit interval inference at rate three");
	a_infer_window: assert property (@(posedge pclk) disable iff (prst_reg)
		idle_inference_select[0] == `PMLI_INFER_EXIT_WIN
			|-> link_rate == `PMLI_RATE_GEN1)
		else $error("exit window inference beyond rate one");
	a_power_hold: assert property (@(posedge pclk) disable iff (prst_reg)
		state_reg == st_wait |=> $stable(power_reg) && $stable(rate_reg))
		else $error("request changed before completion");
	a_rx_narrow: assert property (@(posedge pclk) disable iff (prst_reg)
		!is_gen3 ##1 1'b1 |-> usr_rx_word[0][31:8] == 24'h00_0000)
		else $error("wide receive word at narrow rate");
	a_kind_gen3: assert property (@(posedge pclk) disable iff (prst_reg)
		is_gen3 |=> usr_rx_kind[0] == 4'h0)
		else $error("kind flags passed at rate three");

endmodule

`default_nettype wire

// [pmli_map.svh]
// pmli_map.svh: codes, field positions and reset values of the lane link
// assumes: included by bare name wherever these constants are needed
`ifndef PMLI_MAP_SVH
`define PMLI_MAP_SVH

// signaling rate codes
`define PMLI_RATE_GEN1 2'h0
`define PMLI_RATE_GEN2 2'h1
`define PMLI_RATE_GEN3 2'h2
`define PMLI_RATE_RSVD 2'h3

// power states: fully on, standby, low power, lowest power
`define PMLI_PWR_ON 2'h0
`define PMLI_PWR_STANDBY 2'h1
`define PMLI_PWR_LOW 2'h2
`define PMLI_PWR_LOWEST 2'h3

// idle inference selector codes
`define PMLI_INFER_NONE 3'h0
`define PMLI_INFER_COMSKP 3'h4
`define PMLI_INFER_TS 3'h5
`define PMLI_INFER_EXIT_UI 3'h6
`define PMLI_INFER_EXIT_WIN 3'h7

// coefficient word field positions
`define PMLI_COEF_PRE_LSB 0
`define PMLI_COEF_MAIN_LSB 6
`define PMLI_COEF_POST_LSB 12

// receive width at the first two rates: one byte, one kind bit
`define PMLI_NARROW_MASK 32'h0000_00ff
`define PMLI_NARROW_KIND 4'h1

// reset values
`define PMLI_RST_RATE `PMLI_RATE_GEN1
`define PMLI_RST_PWR `PMLI_PWR_LOW

`endif

// [pmli_pkg.sv]
// pmli_pkg: types shared by the lane controller
// assumes: compiled before the design module
package pmli_pkg;
	typedef enum logic {st_idle, st_wait} pmli_state_t;
	typedef logic [1:0] pmli_rate_t;
	typedef logic [17:0] pmli_coef_t;
endpackage

// [pmli_phy_model.sv]
// pmli_phy_model: behavioural PHY facing the lane controller
// assumes: pclk and sys_rst come from the bench, seed set by the bench
`timescale 1ns/1ps
`default_nettype none
module pmli_phy_model #(
	parameter int LANES = 8
) (
	input wire logic pclk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire logic [LANES-1:0] idle_force,
	input wire logic [LANES-1:0] rx_invert_request,
	input wire logic [LANES-1:0][1:0] power_state_request,
	input wire logic [1:0] link_rate,
	output logic [LANES-1:0] phy_request_done,
	output logic [LANES-1:0] rx_block_begin,
	output logic [LANES-1:0][31:0] rx_lane_word,
	output logic [LANES-1:0][3:0] rx_symbol_kind,
	output logic [LANES-1:0] rx_idle_detected,
	output logic [LANES-1:0] rx_symbol_locked,
	output logic [LANES-1:0][2:0] rx_status_code
);
	logic [LANES-1:0][1:0] pwr_reg;
	logic [1:0] rate_reg;
	int wait_cnt;
	////////////////////////////////////////////////////////////////////////
	// one done pulse per lane after a change; slow stretches the wait
	always @(posedge pclk or posedge sys_rst) begin
		if (sys_rst) begin
			pwr_reg <= {LANES{2'h2}};
			rate_reg <= 2'h0;
			wait_cnt <= 0;
			phy_request_done <= '0;
		end else begin
			pwr_reg <= power_state_request;
			rate_reg <= link_rate;
			phy_request_done <= '0;
			if (pwr_reg != power_state_request || rate_reg != link_rate) begin
				wait_cnt <= (slow ? 60 : 3) + LANES;
			end else if (wait_cnt > 0) begin
				wait_cnt <= wait_cnt - 1;
				if (wait_cnt <= LANES) begin
					phy_request_done[wait_cnt-1] <= 1'b1;
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// fresh noise every edge, so a stale word can never pass for new
	always @(posedge pclk or posedge sys_rst) begin
		if (sys_rst) begin
			{rx_lane_word, rx_symbol_kind, rx_block_begin} <= '0;
			{rx_symbol_locked, rx_status_code, rx_idle_detected} <= '0;
		end else begin
			for (int i = 0; i < LANES; i++) begin
				rx_lane_word[i] <= $urandom ^ {32{rx_invert_request[i]}};
				rx_symbol_kind[i] <= 4'($urandom);
				rx_block_begin[i] <= link_rate == 2'h2 && $urandom % 4 == 0;
				rx_symbol_locked[i] <= $urandom % 8 != 0;
				rx_status_code[i] <= 3'($urandom);
			end
			rx_idle_detected <= idle_force;
		end
	end
endmodule
`default_nettype wire

// [tb.sv]
// tb: random commands and receive traffic through the lane controller
// assumes: the design and the PHY model are compiled before this file
`timescale 1ns/1ps
`default_nettype none
`include "pmli_map.svh"
module tb;
	localparam int L = 8;
	logic clk, pclk, sys_rst, cmd_valid, cmd_ready, cmd_infer_needed;
	logic cmd_error, slow, mon_en, nar;
	logic [1:0] cmd_rate, cmd_power, cmd_infer_code, link_rate, e_rate, e_pwr;
	logic [L-1:0] cmd_invert, stat_idle, rx_invert_request, idle_force;
	logic [L-1:0] phy_request_done, rx_block_begin, rx_idle_detected;
	logic [L-1:0] rx_symbol_locked, usr_rx_valid, usr_rx_block, v_q, b_q;
	logic [5:0] cmd_pre, cmd_main, cmd_post;
	logic [2:0] cmd_preset;
	logic [L-1:0][17:0] tx_equaliser_coefficients;
	logic [L-1:0][2:0] rx_preset_current, idle_inference_select;
	logic [L-1:0][2:0] rx_status_code, usr_rx_status, s_q;
	logic [L-1:0][1:0] power_state_request;
	logic [L-1:0][31:0] rx_lane_word, usr_rx_word, w_q;
	logic [L-1:0][3:0] rx_symbol_kind, usr_rx_kind, k_q;
	int bad_count, check_count, cmd_no;
	pmli_lane_ctrl #(.LANES(L)) pmli_lane_ctrl_inst (.clk(clk),
		.sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_rate(cmd_rate), .cmd_power(cmd_power), .cmd_invert(cmd_invert),
		.cmd_infer_needed(cmd_infer_needed), .cmd_infer_code(cmd_infer_code),
		.cmd_pre(cmd_pre), .cmd_main(cmd_main), .cmd_post(cmd_post),
		.cmd_preset(cmd_preset), .cmd_error(cmd_error), .stat_idle(stat_idle),
		.pclk(pclk), .tx_equaliser_coefficients(tx_equaliser_coefficients),
		.rx_preset_current(rx_preset_current), .link_rate(link_rate),
		.idle_inference_select(idle_inference_select),
		.power_state_request(power_state_request),
		.rx_invert_request(rx_invert_request),
		.phy_request_done(phy_request_done), .rx_block_begin(rx_block_begin),
		.rx_lane_word(rx_lane_word), .rx_symbol_kind(rx_symbol_kind),
		.rx_idle_detected(rx_idle_detected), .rx_status_code(rx_status_code),
		.rx_symbol_locked(rx_symbol_locked), .usr_rx_word(usr_rx_word),
		.usr_rx_kind(usr_rx_kind), .usr_rx_valid(usr_rx_valid),
		.usr_rx_block(usr_rx_block), .usr_rx_status(usr_rx_status));
	pmli_phy_model #(.LANES(L)) pmli_phy_model_inst (.pclk(pclk),
		.sys_rst(sys_rst), .slow(slow), .idle_force(idle_force),
		.rx_invert_request(rx_invert_request), .link_rate(link_rate),
		.power_state_request(power_state_request),
		.phy_request_done(phy_request_done), .rx_block_begin(rx_block_begin),
		.rx_lane_word(rx_lane_word), .rx_symbol_kind(rx_symbol_kind),
		.rx_idle_detected(rx_idle_detected), .rx_status_code(rx_status_code),
		.rx_symbol_locked(rx_symbol_locked));
	////////////////////////////////////////////////////////////////////////
	// two free clocks, phases deliberately unrelated
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	initial begin
		pclk = 0;
		#3.7;
		forever #6 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////////////
	// selector legal only for some rates, otherwise forced to zero
	function automatic logic [2:0] f_sel(logic need, logic [1:0] c,
		logic [1:0] r);
		logic [2:0] s;
		s = {1'b1, c};
		if (!need) return 3'h0;
		if (s == `PMLI_INFER_EXIT_WIN) return r == `PMLI_RATE_GEN1 ? s : 3'h0;
		return r == `PMLI_RATE_GEN3 ? 3'h0 : s;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// one command, valid for one clk edge; waits until ready returns, then checks what it applied
	task automatic send(input logic [1:0] r, input logic [1:0] p);
		int n;
		logic chg, bad;
		bad = r == `PMLI_RATE_RSVD;
		chg = !bad && (r != e_rate || p != e_pwr);
		mon_en = 0;
		cmd_no++;
		cmd_valid = 1;
		{cmd_rate, cmd_power, cmd_invert} = {r, p, 8'($urandom)};
		{cmd_pre, cmd_main, cmd_post, cmd_preset} = 21'($urandom);
		{cmd_infer_needed, cmd_infer_code} = {cmd_no % 5 != 0, 2'(cmd_no)};
		@(posedge clk);
		#2;
		cmd_valid = 0;
		chk(cmd_ready, 0, "ready after take");
		if (!bad) {e_rate, e_pwr} = {r, p};
		for (n = 0; n < 3000 && cmd_ready !== 1'b1; n++) begin
			@(posedge clk);
			#2;
			if (n > 12 && cmd_ready !== 1'b1) begin
				chk(power_state_request, {L{e_pwr}}, "held");
			end
		end
		chk(n < 3000, 1, "ready lost");
		if (slow && chg) chk(n > 30, 1, "no wait for done");
		chk(cmd_error, bad, "error flag");
		chk(link_rate, e_rate, "rate");
		for (int i = 0; i < L; i++) begin
			chk(power_state_request[i], e_pwr, "power");
			// a reserved rate still applies the other fields at the old rate
			chk(rx_invert_request[i], cmd_invert[i], "invert");
			chk(idle_inference_select[i],
				f_sel(cmd_infer_needed, cmd_infer_code, e_rate), "select");
			chk(tx_equaliser_coefficients[i],
				e_rate == `PMLI_RATE_GEN3 ? {cmd_post, cmd_main, cmd_pre}
				: 18'h0_0000, "coef");
			chk(rx_preset_current[i],
				e_rate == `PMLI_RATE_GEN3 ? cmd_preset : 3'h0, "preset");
		end
		mon_en = 1;
		repeat (6) @(posedge clk);
		#2;
	endtask
	////////////////////////////////////////////////////////////////////////
	// receive path: outputs one pclk behind the PHY, narrowed below gen3
	always @(posedge pclk) begin
		#1;
		nar = e_rate != `PMLI_RATE_GEN3;
		for (int i = 0; i < L; i++) if (mon_en) begin
			chk(usr_rx_word[i],
				nar ? w_q[i] & `PMLI_NARROW_MASK : w_q[i], "word");
			chk(usr_rx_kind[i],
				nar ? k_q[i] & `PMLI_NARROW_KIND : 4'h0, "kind");
			chk(usr_rx_valid[i], v_q[i], "valid");
			chk(usr_rx_status[i], s_q[i], "status");
			if (!nar) chk(usr_rx_block[i], b_q[i], "block");
		end
		{w_q, k_q, v_q, s_q, b_q} = {rx_lane_word, rx_symbol_kind,
			rx_symbol_locked, rx_status_code, rx_block_begin};
	end
	// watchdog, far beyond the fewer than a thousand clk cycles the run needs
	initial begin
		#1_000_000;
		bad_count++;
		wrap_up;
	end
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		sys_rst = 1;
		{cmd_valid, cmd_rate, cmd_power, cmd_invert} = '0;
		{cmd_infer_needed, cmd_infer_code, cmd_pre, cmd_main} = '0;
		{cmd_post, cmd_preset, slow, mon_en, idle_force} = '0;
		{bad_count, check_count, cmd_no} = '0;
		{e_rate, e_pwr} = {`PMLI_RST_RATE, `PMLI_RST_PWR};
		void'($urandom(32'hde3ef05e));
		repeat (12) @(posedge clk);
		#2;
		sys_rst = 0;
		chk(link_rate, `PMLI_RATE_GEN1, "reset rate");
		chk(power_state_request, {L{`PMLI_PWR_LOW}}, "reset power");
		chk({cmd_ready, cmd_error}, 2'b10, "reset ready");
		for (int k = 0; k < 12; k++) send(2'(k % 3), 2'(k / 3));
		send(`PMLI_RATE_RSVD, e_pwr);
		repeat (10) send(2'($urandom % 3), 2'($urandom));
		slow = 1;
		repeat (4) send(2'($urandom % 3), 2'($urandom));
		idle_force = 8'($urandom);
		repeat (8) @(posedge clk);
		#2;
		chk(stat_idle, idle_force, "idle");
		wrap_up;
	end
endmodule
`default_nettype wire
